//--- common/status_irq_defines.svh
// constants for the serial status byte and interrupt logic
`ifndef STATUS_IRQ_DEFINES_SVH
`define STATUS_IRQ_DEFINES_SVH
`define SB_RX_READY 0
`define SB_OVERRUN 1
`define SB_PARITY 2
`define SB_FRAMING 3
`define SB_EXT_LEVEL 4
`define SB_PERIPH_EDGE 5
`define SB_TX_SHIFT_EMPTY 6
`define SB_TX_HOLD_EMPTY 7
`define SB_RESET 8'h00
`define SB_SYNC_IDLE 3'h7
`define SB_RST_SYNC_CLEAR 2'h0
`endif

//--- common/status_irq_pkg.sv
// types shared by the serial status and interrupt logic
package status_irq_pkg;
  typedef struct packed {
    logic rx_char_ready;
    logic overrun;
    logic parity_fault;
    logic framing_fault;
    logic ext_level_status;
    logic periph_edge_status;
  } flags_type;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] ext_sync;
    logic [2:0] periph_sync;
    logic periph_prev;
    logic tx_hold_empty_irq;
    logic tdone_irq;
    logic tdone_prev;
    flags_type flags;
    logic [7:0] status_byte;
    logic irq_n;
    logic rx_ready_n;
    logic tx_hold_empty_n;
    logic err_combined;
    logic framing_pin;
  } state_type;
endpackage : status_irq_pkg

//--- src/uart_status_interrupt_logic.sv
// status byte, status pins and interrupt qualification of the serial transceiver
// Behaviour
// - no interrupt until enable bit set
// - holding-empty interrupts only after transmit request set
// - bit 0 set on character transfer
// - bit 1 set when ready still set
// - bit 2 parity fault; OR with overrun pinned
// - bit 3 framing fault, refreshed per transfer, pinned
// - bit 4 follows low external status level
// - bit 5 set on peripheral falling edge
// - ready and holding-empty pins active low
// - clear resets flags, status bits 0 to 5, interrupt
// - data read clears ready and its receive interrupt cause
// - interrupt low while any enabled cause pending
// - holding-empty asserts after move to shifter
`timescale 1ns/1ps
`include "status_irq_defines.svh"
module uart_status_interrupt_logic
  import status_irq_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clear_b_i,
  input wire logic rx_transfer_i,
  input wire logic rx_parity_bad_i,
  input wire logic rx_stop_bad_i,
  input wire logic tx_hold_empty_i,
  input wire logic tx_shift_empty_i,
  input wire logic ext_level_status_b_i,
  input wire logic periph_edge_status_i,
  input wire logic irq_enable_bit_i,
  input wire logic tx_request_bit_i,
  input wire logic read_data_i,
  input wire logic read_status_i,
  input wire logic write_char_i,
  output logic [7:0] serial_status_byte_o,
  output logic irq_b_o,
  output logic rx_char_ready_b_o,
  output logic tx_hold_empty_b_o,
  output logic err_combined_o,
  output logic framing_fault_o
);
  state_type s_q;
  state_type s_d;

  // internal reset copy, released two edges after the pin
  logic rst_b;

  // pin conditions after synchronisation
  logic ext_low;
  logic periph_fall;

  // transmitter conditions, same clock domain
  logic tdone;
  logic tdone_rise;
  logic hold_rise;

  // host side qualifiers
  logic clr;

  // interrupt causes, gathered before the enable gate
  logic cause_rx;
  logic cause_edge;
  logic cause_tx_hold_empty;
  logic cause_done;
  logic pending;

  assign rst_b = s_q.rst_sync[1];

  always_comb begin
    s_d = s_q;

    // reset release chain
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};

    // pin synchronisers, three stages each
    s_d.ext_sync = {s_q.ext_sync[1:0], ext_level_status_b_i};
    s_d.periph_sync = {s_q.periph_sync[1:0], periph_edge_status_i};

    // pin inputs count once stages two and three agree
    ext_low = ~s_q.ext_sync[1] & ~s_q.ext_sync[2];
    if (s_q.periph_sync[1] == s_q.periph_sync[2]) begin
      s_d.periph_prev = s_q.periph_sync[2];
    end
    // prev idles high from reset, so no false edge follows release
    periph_fall = s_q.periph_prev
                & ~s_q.periph_sync[1]
                & ~s_q.periph_sync[2];

    // transmitter done means holding and shift register both empty
    tdone = tx_hold_empty_i & tx_shift_empty_i;
    s_d.tdone_prev = tdone;
    tdone_rise = tdone & ~s_q.tdone_prev;

    // holding-empty edge taken against the registered status bit
    hold_rise = tx_hold_empty_i & ~s_q.status_byte[`SB_TX_HOLD_EMPTY];

    clr = ~clear_b_i;

    // receive side: a transfer in the same cycle as a read wins
    if (read_data_i) begin
      s_d.flags.rx_char_ready = 1'b0;
    end
    if (rx_transfer_i) begin
      s_d.flags.overrun = s_q.flags.rx_char_ready & ~read_data_i;
      s_d.flags.parity_fault = rx_parity_bad_i;
      s_d.flags.framing_fault = rx_stop_bad_i;
      s_d.flags.rx_char_ready = 1'b1;
    end

    // external level is not sticky, it tracks the pin
    s_d.flags.ext_level_status = ext_low;

    // status read clears the edge flag, but a new edge wins
    if (read_status_i) begin
      s_d.flags.periph_edge_status = 1'b0;
      s_d.tdone_irq = 1'b0;
    end
    if (read_status_i | write_char_i) begin
      s_d.tx_hold_empty_irq = 1'b0;
    end
    if (periph_fall) begin
      s_d.flags.periph_edge_status = 1'b1;
    end

    // transmit causes arm only with the request bit set
    if (hold_rise & tx_request_bit_i) begin
      s_d.tx_hold_empty_irq = 1'b1;
    end
    if (tdone_rise & tx_request_bit_i) begin
      s_d.tdone_irq = 1'b1;
    end

    // clear beats every set in the same cycle
    if (clr) begin
      s_d.flags = '0;
      s_d.tx_hold_empty_irq = 1'b0;
      s_d.tdone_irq = 1'b0;
    end

    // status byte assembly
    s_d.status_byte = `SB_RESET;
    s_d.status_byte[`SB_RX_READY] = s_d.flags.rx_char_ready;
    s_d.status_byte[`SB_OVERRUN] = s_d.flags.overrun;
    s_d.status_byte[`SB_PARITY] = s_d.flags.parity_fault;
    s_d.status_byte[`SB_FRAMING] = s_d.flags.framing_fault;
    s_d.status_byte[`SB_EXT_LEVEL] = s_d.flags.ext_level_status;
    s_d.status_byte[`SB_PERIPH_EDGE] = s_d.flags.periph_edge_status;
    s_d.status_byte[`SB_TX_SHIFT_EMPTY] = tx_shift_empty_i;
    s_d.status_byte[`SB_TX_HOLD_EMPTY] = tx_hold_empty_i;

    // interrupt qualification
    cause_rx = s_d.flags.rx_char_ready;
    cause_edge = s_d.flags.periph_edge_status;
    cause_tx_hold_empty = s_d.tx_hold_empty_irq;
    cause_done = s_d.tdone_irq;
    pending = cause_rx
            | cause_edge
            | cause_tx_hold_empty
            | cause_done;
    // clear forces the line inactive in the same cycle
    s_d.irq_n = ~(irq_enable_bit_i & pending & ~clr);

    // pins mirror the byte, ready and holding-empty inverted
    s_d.rx_ready_n = ~s_d.flags.rx_char_ready;
    s_d.tx_hold_empty_n = ~tx_hold_empty_i;
    s_d.err_combined = s_d.flags.parity_fault | s_d.flags.overrun;
    s_d.framing_pin = s_d.flags.framing_fault;
  end

  // both reset branches load the same idle values; the async one
  // needs constants only, so the chain restarts from zero there
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q.rst_sync <= `SB_RST_SYNC_CLEAR;
      s_q.ext_sync <= `SB_SYNC_IDLE;
      s_q.periph_sync <= `SB_SYNC_IDLE;
      s_q.periph_prev <= 1'b1;
      s_q.tx_hold_empty_irq <= 1'b0;
      s_q.tdone_irq <= 1'b0;
      s_q.tdone_prev <= 1'b0;
      s_q.flags <= '0;
      s_q.status_byte <= `SB_RESET;
      s_q.irq_n <= 1'b1;
      s_q.rx_ready_n <= 1'b1;
      s_q.tx_hold_empty_n <= 1'b1;
      s_q.err_combined <= 1'b0;
      s_q.framing_pin <= 1'b0;
    end else if (!rst_b) begin
      s_q.rst_sync <= s_d.rst_sync;
      s_q.ext_sync <= `SB_SYNC_IDLE;
      s_q.periph_sync <= `SB_SYNC_IDLE;
      s_q.periph_prev <= 1'b1;
      s_q.tx_hold_empty_irq <= 1'b0;
      s_q.tdone_irq <= 1'b0;
      s_q.tdone_prev <= 1'b0;
      s_q.flags <= '0;
      s_q.status_byte <= `SB_RESET;
      s_q.irq_n <= 1'b1;
      s_q.rx_ready_n <= 1'b1;
      s_q.tx_hold_empty_n <= 1'b1;
      s_q.err_combined <= 1'b0;
      s_q.framing_pin <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // every output comes straight from a register of the state

  assign serial_status_byte_o = s_q.status_byte;
  assign irq_b_o = s_q.irq_n;
  assign rx_char_ready_b_o = s_q.rx_ready_n;
  assign tx_hold_empty_b_o = s_q.tx_hold_empty_n;
  assign err_combined_o = s_q.err_combined;
  assign framing_fault_o = s_q.framing_pin;
endmodule : uart_status_interrupt_logic

//--- sim/status_periph_model.sv
// peripheral side model driving the status level and edge pins
`timescale 1ns/1ps
module status_periph_model(
  input wire logic core_clk_i,
  input wire logic lvl_i,
  input wire logic drop_i,
  output logic ext_level_status_b_i,
  output logic periph_edge_status_i
);
  // edge line idles high so only a commanded drop makes a falling edge
  always_ff @(posedge core_clk_i) begin
    ext_level_status_b_i <= !lvl_i;
    periph_edge_status_i <= !drop_i;
  end
endmodule : status_periph_model

//--- sim/status_chk.sv
// assertions on the status byte, status pins and interrupt output
`timescale 1ns/1ps
module status_chk(
  input wire logic core_clk_i, rst_b_i, clear_b_i, rx_transfer_i, rx_parity_bad_i,
  rx_stop_bad_i, tx_hold_empty_i, tx_shift_empty_i, ext_level_status_b_i, periph_edge_status_i,
  irq_enable_bit_i, tx_request_bit_i, read_data_i, read_status_i, write_char_i, irq_b_o,
  rx_char_ready_b_o, tx_hold_empty_b_o, err_combined_o, framing_fault_o,
  input wire logic [7:0] serial_status_byte_o
);
  wire [7:0] b = serial_status_byte_o;
  logic [1:0] up_q;
  // the core holds its reset copy two edges past release
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (up_q != 2'h3);
  rx_set_a:
    assert property (rx_transfer_i && clear_b_i |=> b[0]) else $error("ready not set");
  ovr_set_a:
    assert property (rx_transfer_i && b[0] && !read_data_i && clear_b_i |=> b[1]) else $error("no overrun");
  err_pin_a:
    assert property (err_combined_o == (b[1] | b[2])) else $error("error pin wrong");
  frm_pin_a:
    assert property (framing_fault_o == b[3]) else $error("framing pin wrong");
  pin_pol_a:
    assert property (rx_char_ready_b_o == !b[0] && tx_hold_empty_b_o == !b[7]) else $error("pin polarity");
  irq_gate_a:
    assert property (!$past(irq_enable_bit_i) |-> irq_b_o) else $error("irq without enable");
  rd_clr_a:
    assert property (read_data_i && !rx_transfer_i && clear_b_i |=> !b[0]) else $error("ready kept");
  clr_a:
    assert property (!clear_b_i |=> irq_b_o && b[3:0] == 4'h0) else $error("clear failed");
endmodule : status_chk
bind uart_status_interrupt_logic status_chk u_chk(.*);

//--- sim/uart_status_interrupt_logic_test.sv
// bench for the serial status and interrupt logic
`timescale 1ns/1ps
module uart_status_interrupt_logic_test;
  logic core_clk_i = 0, rst_b_i = 0, clear_b_i, rx_transfer_i, read_data_i, read_status_i;
  logic write_char_i, irq_enable_bit_i, tx_request_bit_i, tx_hold_empty_i, tx_shift_empty_i;
  logic rx_parity_bad_i, rx_stop_bad_i, lvl_i, drop_i, ext_level_status_b_i, periph_edge_status_i;
  logic irq_b_o, rx_char_ready_b_o, tx_hold_empty_b_o, err_combined_o, framing_fault_o;
  logic [7:0] serial_status_byte_o, lv = 8'h00;
  logic [4:0] pl = 5'h00;
  int fails = 0, cmp_count = 0;
  // whole output view so every compare also catches stray bits
  wire [12:0] obs = {serial_status_byte_o, irq_b_o, rx_char_ready_b_o, tx_hold_empty_b_o,
    err_combined_o, framing_fault_o};
  assign {irq_enable_bit_i, tx_request_bit_i, tx_hold_empty_i, tx_shift_empty_i, rx_parity_bad_i,
    rx_stop_bad_i, lvl_i, drop_i} = lv;
  assign {clear_b_i, rx_transfer_i, read_data_i, read_status_i, write_char_i} = pl ^ 5'h10;
  uart_status_interrupt_logic u_dut(.*);
  status_periph_model u_per(.*);
  initial forever #4 core_clk_i = !core_clk_i;
  task chk(input logic [12:0] e);
    cmp_count++;
    if (obs !== e) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, obs, e);
    end
  endtask : chk
  task go(input logic [7:0] v, input logic [4:0] p, input int n);
    @(posedge core_clk_i) begin
      lv <= v;
      pl <= p;
    end
    @(posedge core_clk_i) pl <= 5'h00;
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : go
  task t_rx;
    go(8'h00, 5'h08, 0); chk(13'h034);
    go(8'h80, 5'h08, 1); chk(13'h066);
    go(8'h80, 5'h04, 1); chk(13'h05E);
    go(8'h80, 5'h10, 1); chk(13'h01C);
    $display("t_rx done");
  endtask : t_rx
  task t_err;
    go(8'h8C, 5'h08, 1); chk(13'h1A7);
    go(8'h80, 5'h10, 1); chk(13'h01C);
    $display("t_err done");
  endtask : t_err
  task t_tx;
    go(8'hA0, 5'h00, 1); chk(13'h1018);
    go(8'hB0, 5'h00, 1); chk(13'h1818);
    go(8'hD0, 5'h01, 1); chk(13'h081C);
    go(8'hF0, 5'h00, 1); chk(13'h1808);
    go(8'hF0, 5'h02, 1); chk(13'h1818);
    $display("t_tx done");
  endtask : t_tx
  task t_pin;
    go(8'h82, 5'h00, 6); chk(13'h021C);
    go(8'h81, 5'h00, 6); chk(13'h040C);
    go(8'h80, 5'h02, 6); chk(13'h001C);
    $display("t_pin done");
  endtask : t_pin
  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1;
    repeat (3) @(posedge core_clk_i);
    t_rx;
    t_err;
    t_tx;
    t_pin;
    complete_run;
  end
endmodule : uart_status_interrupt_logic_test
